// *** include/ldexec_pkg.sv ***
package ldexec_pkg;
	// Opcodes handled by this block
	localparam logic [7:0] OP_BIT_LOAD = 8'h47;
	localparam logic [7:0] OP_IND_LOAD = 8'hC3;
	localparam logic [7:0] OP_IND_STORE = 8'hD3;
	localparam logic [7:0] OP_SHORT_LOAD = 8'hE7;
	localparam logic [7:0] OP_SHORT_STORE = 8'hF7;
	localparam logic [7:0] OP_LONG_LOAD = 8'hA7;
	localparam logic [7:0] OP_LONG_STORE = 8'hB7;
	// Instruction lengths in cycles
	localparam logic [4:0] CYC_BIT_LOAD = 5'h06;
	localparam logic [4:0] CYC_IND = 5'h0A;
	localparam logic [4:0] CYC_SHORT = 5'h0C;
	localparam logic [4:0] CYC_LONG = 5'h0E;
	// Long-form low nibble codes that mean a direct address
	localparam logic [3:0] DIRECT_PROGRAM = 4'h0;
	localparam logic [3:0] DIRECT_DATA = 4'h1;
	// Memory space select
	localparam logic SPACE_PROGRAM = 1'b0;
	localparam logic SPACE_DATA = 1'b1;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
	} instr_s;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rf_s;

	typedef struct packed {
		logic req;
		logic we;
		logic space;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_s;
endpackage : ldexec_pkg

// *** rtl/bit_and_memory_load_exec.sv ***
// Functional notes
// RL1: bit load copies bit either direction
// RL2: other destination bits and source unchanged
// RL3: no status flag is ever written
// RL4: opcode 47, three bytes, six cycles
// RL5: direction 0 loads, 1 stores bit
// RL6: byte moves to or from memory
// RL7: program and data memory share addressing
// RL8: pair number lsb selects memory space
// RL9: short index E7/F7, twelve cycles, byte offset
// RL10: long index A7/B7, fourteen cycles, word offset
// RL11: software never uses pair 0-1 as index
// RL12: long nibble 0000/0001 means direct address
// RL13: even register high byte, pair untouched
// RL14: mask ROM parts refuse program memory stores
// RL15: index sum is 16-bit, carry dropped
`timescale 1ns/1ns
module bit_and_memory_load_exec #(
	parameter bit MASK_ROM = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_valid,
	input ldexec_pkg::instr_s instr,
	output logic instr_ready,
	input wire logic [3:0] wreg_base,
	output ldexec_pkg::rf_s rf,
	input wire logic [7:0] rf_rdata,
	output ldexec_pkg::mem_s mem,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic flags_we,
	output logic done,
	output logic refused
);
	// ==========================================================
	// Helpers
	typedef enum {S_IDLE, S_RD1, S_RD2, S_RD3, S_MEM, S_WR, S_WAIT} st_e;
	typedef struct packed {
		st_e st;
		logic [4:0] cnt;
		logic [4:0] cyc;
		ldexec_pkg::instr_s ins;
		logic [7:0] tmp;
		logic [7:0] dat;
		logic [7:0] hi;
		logic [7:0] dst;
		logic [15:0] pbase;
		ldexec_pkg::rf_s rf;
		ldexec_pkg::mem_s mem;
		logic done;
		logic refused;
	} state_s;
	state_s s;
	state_s next_s;
	function automatic logic [7:0] work_addr(input logic [3:0] base,
		input logic [3:0] r);
		work_addr = {base, r};
	endfunction : work_addr
	function automatic logic [7:0] put_bit(input logic [7:0] v,
		input logic [2:0] b, input logic x);
		put_bit = v;
		put_bit[b] = x;
	endfunction : put_bit
	function automatic logic is_store(input logic [7:0] op);
		is_store = (op == ldexec_pkg::OP_IND_STORE) ||
			(op == ldexec_pkg::OP_SHORT_STORE) ||
			(op == ldexec_pkg::OP_LONG_STORE);
	endfunction : is_store
	function automatic logic is_long(input logic [7:0] op);
		is_long = (op == ldexec_pkg::OP_LONG_LOAD) ||
			(op == ldexec_pkg::OP_LONG_STORE);
	endfunction : is_long
	function automatic logic is_short(input logic [7:0] op);
		is_short = (op == ldexec_pkg::OP_SHORT_LOAD) ||
			(op == ldexec_pkg::OP_SHORT_STORE);
	endfunction : is_short
	function automatic logic is_mem(input logic [7:0] op);
		is_mem = is_long(op) || is_short(op) ||
			(op == ldexec_pkg::OP_IND_LOAD) ||
			(op == ldexec_pkg::OP_IND_STORE);
	endfunction : is_mem
	function automatic logic is_direct(input ldexec_pkg::instr_s i);
		is_direct = is_long(i.opcode) &&
			(i.b2[3:0] == ldexec_pkg::DIRECT_PROGRAM ||
			i.b2[3:0] == ldexec_pkg::DIRECT_DATA); // RL12
	endfunction : is_direct
	// ==========================================================
	// Sequencer: one transfer per step, then pad to full length
	always_comb begin
		next_s = s;
		next_s.rf.we = 1'b0;
		next_s.done = 1'b0;
		next_s.refused = 1'b0;
		if (s.st != S_IDLE) begin
			next_s.cnt = s.cnt + 5'h01;
		end
		case (s.st)
			S_IDLE: begin
				if (instr_valid) begin
					next_s.ins = instr;
					next_s.cnt = 5'h01;
					next_s.st = S_RD1;
					if (instr.opcode == ldexec_pkg::OP_BIT_LOAD) begin
						next_s.cyc = ldexec_pkg::CYC_BIT_LOAD; // RL4
						// Bit source first, destination second
						if (!instr.b2[0]) begin // RL5
							next_s.rf.addr = instr.b3;
							next_s.dst = work_addr(wreg_base, instr.b2[7:4]);
						end else begin
							next_s.rf.addr = work_addr(wreg_base, instr.b2[7:4]);
							next_s.dst = instr.b3;
						end
					end else if (is_mem(instr.opcode)) begin
						next_s.dst = work_addr(wreg_base, instr.b2[7:4]);
						next_s.cyc = is_long(instr.opcode) ?
							ldexec_pkg::CYC_LONG : is_short(instr.opcode) ?
							ldexec_pkg::CYC_SHORT : ldexec_pkg::CYC_IND; // RL9 RL10
						next_s.mem.space = instr.b2[0]; // RL8 RL7
						// Even register of the pair is read first
						next_s.rf.addr = work_addr(wreg_base,
							{instr.b2[3:1], 1'b0}); // RL13
						if (is_direct(instr)) begin
							next_s.pbase = {instr.b4, instr.b3}; // RL12
							next_s.st = S_RD3;
							next_s.rf.addr = next_s.dst;
						end
					end else begin
						// Not ours: answer at once so fetch never hangs
						next_s.refused = 1'b1;
						next_s.done = 1'b1;
						next_s.st = S_IDLE;
					end
				end
			end
			S_RD1: begin
				if (s.ins.opcode == ldexec_pkg::OP_BIT_LOAD) begin
					next_s.tmp = rf_rdata;
					next_s.rf.addr = s.dst;
				end else begin
					next_s.hi = rf_rdata;
					next_s.rf.addr = work_addr(wreg_base,
						{s.ins.b2[3:1], 1'b1});
				end
				next_s.st = S_RD2;
			end
			S_RD2: begin
				if (s.ins.opcode == ldexec_pkg::OP_BIT_LOAD) begin
					next_s.dat = rf_rdata;
					next_s.st = S_WR;
				end else begin
					next_s.pbase = {s.hi, rf_rdata}; // RL13
					next_s.rf.addr = s.dst;
					next_s.st = S_RD3;
				end
			end
			S_RD3: begin
				// Offset added in 16 bits; carry out falls off
				if (is_short(s.ins.opcode)) begin
					next_s.mem.addr = s.pbase + {8'h00, s.ins.b3}; // RL15 RL9
				end else if (is_long(s.ins.opcode) && !is_direct(s.ins)) begin
					next_s.mem.addr = s.pbase + {s.ins.b4, s.ins.b3}; // RL10
				end else begin
					next_s.mem.addr = s.pbase;
				end
				next_s.mem.wdata = rf_rdata;
				next_s.mem.we = is_store(s.ins.opcode); // RL6
				if (MASK_ROM && is_store(s.ins.opcode) &&
					s.mem.space == ldexec_pkg::SPACE_PROGRAM) begin
					next_s.refused = 1'b1; // RL14
					next_s.st = S_WAIT;
				end else begin
					next_s.mem.req = 1'b1;
					next_s.st = S_MEM;
				end
			end
			S_MEM: begin
				if (mem_ack) begin
					next_s.mem.req = 1'b0;
					next_s.mem.we = 1'b0;
					next_s.dat = mem_rdata;
					next_s.st = s.mem.we ? S_WAIT : S_WR;
				end
			end
			S_WR: begin
				next_s.rf.we = 1'b1;
				next_s.rf.addr = s.dst;
				if (s.ins.opcode != ldexec_pkg::OP_BIT_LOAD) begin
					next_s.rf.wdata = s.dat; // RL6
				end else if (!s.ins.b2[0]) begin
					next_s.rf.wdata = put_bit(s.dat, 3'h0,
						s.tmp[s.ins.b2[3:1]]); // RL1 RL2
				end else begin
					next_s.rf.wdata = put_bit(s.dat, s.ins.b2[3:1],
						s.tmp[0]); // RL1 RL2
				end
				next_s.st = S_WAIT;
			end
			S_WAIT: begin
				if (s.cnt >= s.cyc - 5'h01) begin
					next_s.done = 1'b1;
					next_s.st = S_IDLE;
				end
			end
			default: begin
				next_s.st = S_IDLE;
			end
		endcase
	end
	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	// Outputs; flags are never written by these instructions
	assign instr_ready = (s.st == S_IDLE);
	assign rf = s.rf;
	assign mem = s.mem;
	assign done = s.done;
	assign refused = s.refused;
	assign flags_we = 1'b0; // RL3

	// ==========================================================
	// Checks
	wire logic fire = instr_valid && instr_ready;
	property p_flags;
		@(posedge clk_sys) disable iff (!rst_n)
		(s.st != S_IDLE) |-> !flags_we;
	endproperty
	a_flags: assert property (p_flags) else $error("flags written"); // RL3
	property p_bit_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		(rf.we && s.ins.opcode == ldexec_pkg::OP_BIT_LOAD) |->
		($countones(rf.wdata ^ s.dat) <= 1);
	endproperty
	a_bit_keep: assert property (p_bit_keep) else $error("bits lost"); // RL2
	property p_bit_val;
		@(posedge clk_sys) disable iff (!rst_n)
		(rf.we && s.ins.opcode == ldexec_pkg::OP_BIT_LOAD) |->
		(s.ins.b2[0] ? rf.wdata[s.ins.b2[3:1]] == s.tmp[0] :
		rf.wdata[0] == s.tmp[s.ins.b2[3:1]]);
	endproperty
	a_bit_val: assert property (p_bit_val) else $error("bad bit"); // RL1 RL5
	// Done is registered, so it is first seen high six edges after taking;
	// the taking edge itself may still see the previous done pulse
	property p_bit_len;
		@(posedge clk_sys) disable iff (!rst_n)
		(fire && instr.opcode == ldexec_pkg::OP_BIT_LOAD) |->
		##1 !done [*5] ##1 done;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit len"); // RL4
	property p_ind_len;
		@(posedge clk_sys) disable iff (!rst_n)
		(fire && (instr.opcode == ldexec_pkg::OP_IND_LOAD ||
		instr.opcode == ldexec_pkg::OP_IND_STORE)) |->
		##[10:200] done;
	endproperty
	a_ind_len: assert property (p_ind_len) else $error("ind len"); // RL6
	property p_space;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(mem.req) |-> (mem.space == s.ins.b2[0]);
	endproperty
	a_space: assert property (p_space) else $error("bad space"); // RL8 RL7
	property p_short_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(mem.req) && is_short(s.ins.opcode)) |->
		(mem.addr == 16'(s.pbase + {8'h00, s.ins.b3}));
	endproperty
	a_short_addr: assert property (p_short_addr) else $error("xs"); // RL9 RL15
	property p_long_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(mem.req) && is_long(s.ins.opcode)) |->
		(mem.addr == (is_direct(s.ins) ? {s.ins.b4, s.ins.b3} :
		16'(s.pbase + {s.ins.b4, s.ins.b3})));
	endproperty
	a_long_addr: assert property (p_long_addr) else $error("xl"); // RL10 RL12
	property p_pair_kept;
		@(posedge clk_sys) disable iff (!rst_n)
		(rf.we && is_mem(s.ins.opcode)) |->
		(rf.addr == work_addr(wreg_base, s.ins.b2[7:4]) && !s.mem.we);
	endproperty
	a_pair_kept: assert property (p_pair_kept) else $error("pair hit"); // RL13
	property p_rom;
		@(posedge clk_sys) disable iff (!rst_n)
		(mem.req && mem.we) |->
		!(MASK_ROM && mem.space == ldexec_pkg::SPACE_PROGRAM);
	endproperty
	a_rom: assert property (p_rom) else $error("rom store"); // RL14
	c_bit_store: cover property (@(posedge clk_sys)
		fire && instr.opcode == ldexec_pkg::OP_BIT_LOAD && instr.b2[0]);
	c_data_load: cover property (@(posedge clk_sys)
		$rose(mem.req) && !mem.we && mem.space);
	c_direct: cover property (@(posedge clk_sys)
		$rose(mem.req) && is_direct(s.ins));
	c_refused: cover property (@(posedge clk_sys) refused);
endmodule : bit_and_memory_load_exec

// *** sim/mem_model.sv ***
`timescale 1ns/1ns
// =====================================================
// Program and external data memory behind the core
module mem_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input ldexec_pkg::mem_s mem,
	input wire logic [3:0] slow,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	// Full 64K arrays: free simulators handle these better than maps
	logic [7:0] pm [65536];
	logic [7:0] dm [65536];
	logic [3:0] wait_cnt;

	// One answer per request after slow idle cycles; the data lines
	// toggle when not answering, so stale data never looks valid
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			wait_cnt <= 4'h0;
			mem_rdata <= 8'h5A;
		end else if (mem.req && !mem_ack && wait_cnt == slow) begin
			mem_ack <= 1'b1;
			wait_cnt <= 4'h0;
			if (!mem.we)
				mem_rdata <= mem.space ? dm[mem.addr] : pm[mem.addr];
			else if (mem.space)
				dm[mem.addr] <= mem.wdata;
			else
				pm[mem.addr] <= mem.wdata;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem.req && !mem_ack)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : mem_model

// *** sim/bit_and_memory_load_exec_tb_top.sv ***
`timescale 1ns/1ns
module bit_and_memory_load_exec_tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	ldexec_pkg::instr_s instr = '0;
	logic [3:0] wreg_base = 4'hC;
	logic [3:0] slow = 4'h0;
	logic [7:0] rf_rdata, mem_rdata;
	logic instr_ready, mem_ack, flags_we, done, refused;
	ldexec_pkg::rf_s rf;
	ldexec_pkg::mem_s mem;
	logic [7:0] regs [256];
	int err_count = 0;
	int samples_checked = 0;

	// =====================================================
	// Clock, register file and instances
	always #2 clk_sys = ~clk_sys;
	assign rf_rdata = regs[rf.addr];
	always @(posedge clk_sys) begin
		if (rf.we)
			regs[rf.addr] <= rf.wdata;
	end
	// Flag writes are checked on every cycle, not per scenario
	always @(negedge clk_sys) begin
		if (rst_n)
			chk("flags_we", 16'h0, {15'h0, flags_we});
	end

	bit_and_memory_load_exec bit_and_memory_load_exec_i (.clk_sys, .rst_n,
		.instr_valid, .instr, .instr_ready, .wreg_base, .rf, .rf_rdata,
		.mem, .mem_ack, .mem_rdata, .flags_we, .done, .refused);
	mem_model mem_model_i (.clk_sys, .rst_n, .mem, .slow, .mem_ack,
		.mem_rdata);

	// =====================================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// Offer one instruction; cycles counted from the taking edge
	task automatic run(input logic [7:0] op, b2, b3, b4, input int cyc,
		input logic rfs);
		int n;
		@(negedge clk_sys);
		chk("instr_ready", 16'h1, {15'h0, instr_ready});
		instr = '{op, b2, b3, b4};
		instr_valid = 1'b1;
		@(negedge clk_sys);
		instr_valid = 1'b0;
		n = 1;
		while (done !== 1'b1) begin
			if (n > 40) begin
				err_count++;
				final_report();
			end
			@(negedge clk_sys);
			n++;
		end
		if (cyc > 0)
			chk("cycles", cyc[15:0], n[15:0]);
		chk("refused", {15'h0, rfs}, {15'h0, refused});
	endtask : run

	// =====================================================
	// Scenarios
	task automatic t_bit_in();
		regs[8'hC0] = 8'h06;
		regs[8'h00] = 8'h05;
		run(8'h47, 8'h04, 8'h00, 8'h00, 6, 1'b0);
		chk("bit dst", 16'h07, {8'h0, regs[8'hC0]});
		chk("bit src", 16'h05, {8'h0, regs[8'h00]});
	endtask : t_bit_in

	// Bit seven cleared, other bits must survive
	task automatic t_bit_out();
		regs[8'hC5] = 8'hFE;
		regs[8'h3A] = 8'hFF;
		run(8'h47, 8'h5F, 8'h3A, 8'h00, 6, 1'b0);
		chk("bit dst", 16'h7F, {8'h0, regs[8'h3A]});
		chk("bit src", 16'hFE, {8'h0, regs[8'hC5]});
	endtask : t_bit_out

	task automatic t_ind();
		regs[8'hC2] = 8'h01;
		regs[8'hC3] = 8'h04;
		mem_model_i.pm[16'h0104] = 8'h1A;
		run(8'hC3, 8'h12, 8'h00, 8'h00, 10, 1'b0);
		chk("ind ld", 16'h1A, {8'h0, regs[8'hC1]});
		regs[8'hC1] = 8'h11;
		run(8'hD3, 8'h13, 8'h00, 8'h00, 10, 1'b0);
		chk("ind st", 16'h11, {8'h0, mem_model_i.dm[16'h0104]});
		chk("pair", 16'h0104, {regs[8'hC2], regs[8'hC3]});
	endtask : t_ind

	// Slow memory; offset above 7F must not be sign extended
	task automatic t_short();
		slow = 4'h3;
		mem_model_i.pm[16'h01F4] = 8'h5C;
		run(8'hE7, 8'h02, 8'hF0, 8'h00, 0, 1'b0);
		chk("short ld", 16'h5C, {8'h0, regs[8'hC0]});
		run(8'hF7, 8'h03, 8'h01, 8'h00, 0, 1'b0);
		chk("short st", 16'h5C, {8'h0, mem_model_i.dm[16'h0105]});
		slow = 4'h0;
	endtask : t_short

	// Sum wraps past FFFF
	task automatic t_long();
		regs[8'hC4] = 8'hF0;
		regs[8'hC5] = 8'h00;
		mem_model_i.dm[16'h1000] = 8'h3E;
		run(8'hA7, 8'h05, 8'h00, 8'h20, 14, 1'b0);
		chk("long ld", 16'h3E, {8'h0, regs[8'hC0]});
		run(8'hB7, 8'h02, 8'h00, 8'h10, 14, 1'b0);
		chk("long st", 16'h3E, {8'h0, mem_model_i.pm[16'h1104]});
		chk("pair", 16'hF000, {regs[8'hC4], regs[8'hC5]});
	endtask : t_long

	task automatic t_direct();
		mem_model_i.dm[16'h1104] = 8'h98;
		run(8'hA7, 8'h11, 8'h04, 8'h11, 14, 1'b0);
		chk("direct ld", 16'h98, {8'h0, regs[8'hC1]});
		run(8'hB7, 8'h10, 8'h05, 8'h11, 14, 1'b0);
		chk("direct st", 16'h98, {8'h0, mem_model_i.pm[16'h1105]});
	endtask : t_direct

	task automatic t_refused();
		run(8'h00, 8'h00, 8'h00, 8'h00, 1, 1'b1);
	endtask : t_refused

	initial begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		t_bit_in();
		t_bit_out();
		t_ind();
		t_short();
		t_long();
		t_direct();
		t_refused();
		final_report();
	end
endmodule : bit_and_memory_load_exec_tb_top
